// file: common/stf_pkg.sv
// Constants and types shared by the scan test and float control block.
// Assumes a single core clock; all test pins arrive asynchronously.
//
// Functional notes
// - Sample TMS into TAP on TCK rise.
// - Capture TDI into selected register on rise.
// - TDO changes only on TCK falling edges.
// - TDO high impedance except while shifting.
// - Test reset high: scan controls; low: functional.
// - Event pin 0 bidirectional, direction via scan.
// - Event pin 1 bidirectional, direction via scan.
// - Test reset low: pin 1 is float request.
// - Float all outputs on reset-low, pin0-high, pin1-low.
package stf_pkg;

  // ---------------------------------------------------------------------
  // Timing and structure
  // ---------------------------------------------------------------------
  localparam int CORE_CLK_PERIOD_NS = 5;
  localparam int SYNC_STAGES        = 3;
  localparam int IR_WIDTH           = 4;
  localparam int EMU_DR_WIDTH       = 2;

  // ---------------------------------------------------------------------
  // Instruction codes and reset values
  // ---------------------------------------------------------------------
  localparam logic [3:0] INSN_BYPASS     = 4'hf;
  localparam logic [3:0] INSN_EMU_CTRL   = 4'h2;
  localparam logic [3:0] IR_CAPTURE_VAL  = 4'h1;
  localparam logic [1:0] EMU_DIR_RESET   = 2'h0;

  // Test access port controller states.
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UP_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
  } stf_tap_t;

endpackage : stf_pkg

// file: src/stf_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output is a clean level on clk.
`timescale 1ns/10ps
module stf_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } stf_sync_st_t;

  stf_sync_st_t s_reg;
  stf_sync_st_t s_next;

  // A bit moves only when stages two and three agree, so a value
  // sampled mid-transition never reaches the logic downstream.
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.q  = (s_reg.s2 & ~(s_reg.s2 ^ s_reg.s3)) | (s_reg.q & (s_reg.s2 ^ s_reg.s3));
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= {INIT, INIT, INIT, INIT};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.q;

endmodule : stf_sync

// file: src/stf_top.sv
// Boundary-scan test port and output-float control of the processor.
// Assumes TCK, TMS, TDI, TRST and the emulator event pins are asynchronous
// to CORE_CLK; TCK must be slower than a quarter of CORE_CLK.
`timescale 1ns/10ps
module stf_top (
  input  wire logic CORE_CLK,
  input  wire logic RESET,
  input  wire logic TCK,
  input  wire logic TMS,
  input  wire logic TDI,
  input  wire logic TRST,
  input  wire logic EMULATOR_EVENT_PIN0_IN,
  input  wire logic EMULATOR_EVENT_PIN1_FLOAT_SELECT_IN,
  input  wire logic CORE_EVENT0,
  input  wire logic CORE_EVENT1,
  output logic      TDO,
  output logic      TDO_OE,
  output logic      EMULATOR_EVENT_PIN0_OUT,
  output logic      EMULATOR_EVENT_PIN0_OE,
  output logic      EMULATOR_EVENT_PIN1_FLOAT_SELECT_OUT,
  output logic      EMULATOR_EVENT_PIN1_FLOAT_SELECT_OE,
  output logic      EMU_EVENT0_TO_CORE,
  output logic      EMU_EVENT1_TO_CORE,
  output logic      SCAN_ACTIVE,
  output logic      FLOAT_ALL
);

  // -----------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------
  logic [5:0] pins_s;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic       trst_s;
  logic       emulator_event_pin0_s;
  logic       emu1_s;

  // Idle levels follow the pin pulls: TMS and TDI high, TRST low.
  stf_sync #(
    .WIDTH (6),
    .INIT  (6'h36)
  ) u_pin_sync (
    .clk (CORE_CLK),
    .rst (RESET),
    .d   ({EMULATOR_EVENT_PIN1_FLOAT_SELECT_IN, EMULATOR_EVENT_PIN0_IN,
           TRST, TDI, TMS, TCK}),
    .q   (pins_s)
  );

  assign tck_s  = pins_s[0];
  assign tms_s  = pins_s[1];
  assign tdi_s  = pins_s[2];
  assign trst_s = pins_s[3];
  assign emulator_event_pin0_s = pins_s[4];
  assign emu1_s = pins_s[5];

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    stf_pkg::stf_tap_t               tap;
    logic [stf_pkg::IR_WIDTH-1:0]    ir;
    logic [stf_pkg::IR_WIDTH-1:0]    ir_sr;
    logic [stf_pkg::EMU_DR_WIDTH-1:0] dr_sr;
    logic [stf_pkg::EMU_DR_WIDTH-1:0] dir;
    logic                            tck_prev;
    logic                            tdo;
    logic                            tdo_oe;
    logic                            emulator_event_pin0_out;
    logic                            emulator_event_pin0_oe;
    logic                            emu1_out;
    logic                            emu1_oe;
    logic                            ev0;
    logic                            ev1;
    logic                            float_all;
  } stf_top_st_t;

  stf_top_st_t s_reg;
  stf_top_st_t s_next;

  logic tck_rise;
  logic tck_fall;
  logic scan_on;
  logic float_req;
  logic shifting;
  logic sel_emu;

  // Edges are found on the filtered TCK level, so one edge is one event.
  assign tck_rise  = tck_s & ~s_reg.tck_prev;
  assign tck_fall  = ~tck_s & s_reg.tck_prev;
  assign scan_on   = trst_s;
  assign float_req = ~trst_s & emulator_event_pin0_s & ~emu1_s;
  assign shifting  = (s_reg.tap == stf_pkg::ST_SH_DR) || (s_reg.tap == stf_pkg::ST_SH_IR);
  assign sel_emu   = (s_reg.ir == stf_pkg::INSN_EMU_CTRL);

  // -----------------------------------------------------------------------
  // TAP next-state function
  // -----------------------------------------------------------------------
  function automatic stf_pkg::stf_tap_t tap_step(input stf_pkg::stf_tap_t st,
                                                 input logic tms);
    stf_pkg::stf_tap_t nx;
    nx = st;
    unique case (st)
      stf_pkg::ST_TLR:    nx = tms ? stf_pkg::ST_TLR    : stf_pkg::ST_RTI;
      stf_pkg::ST_RTI:    nx = tms ? stf_pkg::ST_SEL_DR : stf_pkg::ST_RTI;
      stf_pkg::ST_SEL_DR: nx = tms ? stf_pkg::ST_SEL_IR : stf_pkg::ST_CAP_DR;
      stf_pkg::ST_CAP_DR: nx = tms ? stf_pkg::ST_EX1_DR : stf_pkg::ST_SH_DR;
      stf_pkg::ST_SH_DR:  nx = tms ? stf_pkg::ST_EX1_DR : stf_pkg::ST_SH_DR;
      stf_pkg::ST_EX1_DR: nx = tms ? stf_pkg::ST_UP_DR  : stf_pkg::ST_PA_DR;
      stf_pkg::ST_PA_DR:  nx = tms ? stf_pkg::ST_EX2_DR : stf_pkg::ST_PA_DR;
      stf_pkg::ST_EX2_DR: nx = tms ? stf_pkg::ST_UP_DR  : stf_pkg::ST_SH_DR;
      stf_pkg::ST_UP_DR:  nx = tms ? stf_pkg::ST_SEL_DR : stf_pkg::ST_RTI;
      stf_pkg::ST_SEL_IR: nx = tms ? stf_pkg::ST_TLR    : stf_pkg::ST_CAP_IR;
      stf_pkg::ST_CAP_IR: nx = tms ? stf_pkg::ST_EX1_IR : stf_pkg::ST_SH_IR;
      stf_pkg::ST_SH_IR:  nx = tms ? stf_pkg::ST_EX1_IR : stf_pkg::ST_SH_IR;
      stf_pkg::ST_EX1_IR: nx = tms ? stf_pkg::ST_UP_IR  : stf_pkg::ST_PA_IR;
      stf_pkg::ST_PA_IR:  nx = tms ? stf_pkg::ST_EX2_IR : stf_pkg::ST_PA_IR;
      stf_pkg::ST_EX2_IR: nx = tms ? stf_pkg::ST_UP_IR  : stf_pkg::ST_SH_IR;
      stf_pkg::ST_UP_IR:  nx = tms ? stf_pkg::ST_SEL_DR : stf_pkg::ST_RTI;
    endcase
    return nx;
  endfunction : tap_step

  // -----------------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------------
  // With test reset low the controller is held in reset and every scan
  // input is ignored, so the device runs purely in functional mode.
  always_comb begin
    s_next          = s_reg;
    s_next.tck_prev = tck_s;
    if (!scan_on) begin
      s_next.tap = stf_pkg::ST_TLR;
      s_next.ir  = stf_pkg::INSN_BYPASS;
      s_next.dir = stf_pkg::EMU_DIR_RESET;
    end else if (tck_rise) begin
      s_next.tap = tap_step(s_reg.tap, tms_s);
      unique case (s_reg.tap)
        stf_pkg::ST_TLR:    s_next.ir = stf_pkg::INSN_BYPASS;
        stf_pkg::ST_CAP_IR: s_next.ir_sr = stf_pkg::IR_CAPTURE_VAL;
        stf_pkg::ST_SH_IR:  s_next.ir_sr = {tdi_s, s_reg.ir_sr[stf_pkg::IR_WIDTH-1:1]};
        stf_pkg::ST_UP_IR:  s_next.ir = s_reg.ir_sr;
        stf_pkg::ST_CAP_DR: s_next.dr_sr = sel_emu ? {emu1_s, emulator_event_pin0_s} : 2'h0;
        stf_pkg::ST_SH_DR: begin
          // Bypass is one bit long; the event-direction register is two.
          if (sel_emu) begin
            s_next.dr_sr = {tdi_s, s_reg.dr_sr[1]};
          end else begin
            s_next.dr_sr = {1'b0, tdi_s};
          end
        end
        stf_pkg::ST_UP_DR: begin
          if (sel_emu) begin
            s_next.dir = s_reg.dr_sr;
          end
        end
        default: s_next.ir = s_reg.ir;
      endcase
    end

    // The output bit moves only on falling TCK edges; its enable also clears whenever test reset is low.
    if (!scan_on) begin
      s_next.tdo_oe = 1'b0;
    end else if (tck_fall) begin
      s_next.tdo    = (s_reg.tap == stf_pkg::ST_SH_IR) ? s_reg.ir_sr[0] : s_reg.dr_sr[0];
      s_next.tdo_oe = shifting;
    end

    // Event pins drive only in scan mode and only when set as outputs.
    s_next.emulator_event_pin0_out  = CORE_EVENT0;
    s_next.emu1_out  = CORE_EVENT1;
    s_next.emulator_event_pin0_oe   = scan_on & s_reg.dir[0];
    s_next.emu1_oe   = scan_on & s_reg.dir[1];
    s_next.ev0       = scan_on & ~s_reg.dir[0] & emulator_event_pin0_s;
    s_next.ev1       = scan_on & ~s_reg.dir[1] & emu1_s;
    s_next.float_all = float_req;
  end

  // State register.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      s_reg          <= '0;
      s_reg.tap      <= stf_pkg::ST_TLR;
      s_reg.ir       <= stf_pkg::INSN_BYPASS;
      s_reg.ir_sr    <= stf_pkg::IR_CAPTURE_VAL;
      s_reg.dir      <= stf_pkg::EMU_DIR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  // The float condition overrides every enable, this block's own included.
  assign TDO                                  = s_reg.tdo;
  assign TDO_OE                               = s_reg.tdo_oe & ~s_reg.float_all;
  assign EMULATOR_EVENT_PIN0_OUT              = s_reg.emulator_event_pin0_out;
  assign EMULATOR_EVENT_PIN0_OE               = s_reg.emulator_event_pin0_oe & ~s_reg.float_all;
  assign EMULATOR_EVENT_PIN1_FLOAT_SELECT_OUT = s_reg.emu1_out;
  assign EMULATOR_EVENT_PIN1_FLOAT_SELECT_OE  = s_reg.emu1_oe & ~s_reg.float_all;
  assign EMU_EVENT0_TO_CORE                   = s_reg.ev0;
  assign EMU_EVENT1_TO_CORE                   = s_reg.ev1;
  assign SCAN_ACTIVE                          = scan_on;
  assign FLOAT_ALL                            = s_reg.float_all;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  chk_tms_sample_tlr: assert property (
    scan_on && tck_rise && s_reg.tap == stf_pkg::ST_TLR && !tms_s |=> s_reg.tap == stf_pkg::ST_RTI)
    else $error("TMS low at TCK rise did not leave reset state.");

  chk_tdi_capture_ir: assert property (
    scan_on && tck_rise && s_reg.tap == stf_pkg::ST_SH_IR |=> s_reg.ir_sr[3] == $past(tdi_s))
    else $error("TDI not captured into instruction shifter.");

  chk_tdo_fall_only: assert property (
    $changed(TDO) |-> $past(tck_fall))
    else $error("TDO changed without a falling TCK edge.");

  chk_tdo_hiz_idle: assert property (
    TDO_OE |-> $past(scan_on) && ($past(shifting) || $past(TDO_OE)))
    else $error("TDO enabled outside a shift.");

  chk_tdo_oe_drop: assert property (
    scan_on && tck_fall && !shifting |=> !TDO_OE)
    else $error("TDO still enabled after the shift ended.");

  chk_tdo_off_func: assert property (
    !scan_on |=> !TDO_OE)
    else $error("TDO enabled in functional mode.");

  chk_func_tap_reset: assert property (
    !scan_on |=> s_reg.tap == stf_pkg::ST_TLR ##0 s_reg.ir == stf_pkg::INSN_BYPASS)
    else $error("TAP not held in reset with test reset low.");

  chk_emulator_event_pin0_dir_drive: assert property (
    EMULATOR_EVENT_PIN0_OE |-> $past(scan_on) && $past(s_reg.dir[0]))
    else $error("Event pin 0 driven without output direction.");

  chk_emu1_dir_drive: assert property (
    EMULATOR_EVENT_PIN1_FLOAT_SELECT_OE |-> $past(scan_on) && $past(s_reg.dir[1]))
    else $error("Event pin 1 driven without output direction.");

  chk_emu1_float_in: assert property (
    !scan_on ##1 !scan_on |-> !EMULATOR_EVENT_PIN1_FLOAT_SELECT_OE && !EMU_EVENT1_TO_CORE)
    else $error("Event pin 1 not treated as float input.");

  chk_float_all_cond: assert property (
    ##1 FLOAT_ALL == $past(!trst_s && emulator_event_pin0_s && !emu1_s))
    else $error("Float output does not follow pin combination.");

  chk_update_ir_load: assert property (
    scan_on && tck_rise && s_reg.tap == stf_pkg::ST_UP_IR |=> s_reg.ir == $past(s_reg.ir_sr))
    else $error("Instruction not loaded at update.");

  cov_shift_dr: cover property (scan_on && tck_fall && s_reg.tap == stf_pkg::ST_SH_DR);
  cov_emu_dir_set: cover property (scan_on && sel_emu && tck_rise && s_reg.tap == stf_pkg::ST_UP_DR);
  cov_float: cover property (FLOAT_ALL);

endmodule : stf_top

// file: tb/stf_tester.sv
// Model of the external scan tester and emulator pod facing the device.
// Assumes the device filters every pin with its own core-clock synchronisers.
`timescale 1ns/10ps
module stf_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst,
  input  wire logic dev_tdo,
  input  wire logic dev_tdo_oe,
  input  wire logic pin0_out,
  input  wire logic pin0_oe,
  input  wire logic pin1_out,
  input  wire logic pin1_oe,
  output logic pin0_lvl,
  output logic pin1_lvl
);
  localparam time HALF = 40ns;
  logic emulator_event_pin0_drv;
  logic emu1_drv;

  // The pod lets go of a pin while the device drives it.
  assign pin0_lvl = pin0_oe ? pin0_out : emulator_event_pin0_drv;
  assign pin1_lvl = pin1_oe ? pin1_out : emu1_drv;

  // Pullup idle levels; test reset low keeps the device functional.
  initial begin
    {tck, tms, tdi, trst} = 4'h6;
    {emulator_event_pin0_drv, emu1_drv} = 2'h3;
  end

  task automatic set_pins(input logic t, input logic e0, input logic e1);
    {trst, emulator_event_pin0_drv, emu1_drv} = {t, e0, e1};
  endtask : set_pins

  // Even-duty clock runs only inside a scan; TDO is read just before each
  // rise and again before the fall, so a change in the high phase shows.
  task automatic scan(input int n, input logic [15:0] tms_v, input logic [15:0] tdi_v,
                      output logic [15:0] tdo_v, output logic [15:0] oe_v,
                      output logic [15:0] chg_v);
    {tdo_v, oe_v, chg_v} = '0;
    for (int i = 0; i < n; i++) begin
      tms = tms_v[i];
      tdi = tdi_v[i];
      #(HALF);
      tdo_v[i] = dev_tdo;
      oe_v[i] = dev_tdo_oe;
      tck = 1'b1;
      #(HALF);
      chg_v[i] = (dev_tdo !== tdo_v[i]);
      tck = 1'b0;
    end
    // Idle levels return with the last fall, then a half period passes, so
    // a following scan never moves TMS or TDI twice in one time step.
    {tms, tdi} = 2'h3;
    #(HALF);
  endtask : scan
endmodule : stf_tester

// file: tb/stf_top_test.sv
// Self-checking bench for the scan port and output-float logic.
// Assumes the tester model drives every link pin; core pins move after clk.
`timescale 1ns/10ps
module stf_top_test;
  logic        clk, rst, ev0, ev1, tck, tms, tdi, trst, p0, p1;
  logic        tdo, tdo_oe, p0_out, p0_oe, p1_out, p1_oe, ev0_core, ev1_core, scan_on, flt;
  logic [15:0] tdo_v, oe_v, chg_v;
  int          mismatches = 0;
  int          check_count = 0;

  stf_top u_dut (.CORE_CLK(clk), .RESET(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST(trst),
    .EMULATOR_EVENT_PIN0_IN(p0), .EMULATOR_EVENT_PIN1_FLOAT_SELECT_IN(p1),
    .CORE_EVENT0(ev0), .CORE_EVENT1(ev1), .TDO(tdo), .TDO_OE(tdo_oe),
    .EMULATOR_EVENT_PIN0_OUT(p0_out), .EMULATOR_EVENT_PIN0_OE(p0_oe),
    .EMULATOR_EVENT_PIN1_FLOAT_SELECT_OUT(p1_out), .EMULATOR_EVENT_PIN1_FLOAT_SELECT_OE(p1_oe),
    .EMU_EVENT0_TO_CORE(ev0_core), .EMU_EVENT1_TO_CORE(ev1_core),
    .SCAN_ACTIVE(scan_on), .FLOAT_ALL(flt));

  stf_tester u_tester (.tck(tck), .tms(tms), .tdi(tdi), .trst(trst), .dev_tdo(tdo),
    .dev_tdo_oe(tdo_oe), .pin0_out(p0_out), .pin0_oe(p0_oe), .pin1_out(p1_out),
    .pin1_oe(p1_oe), .pin0_lvl(p0), .pin1_lvl(p1));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic check_bits(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bits

  // Pins pass a three-flop filter, so a fixed margin covers their delay.
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask : settle

  task automatic status(input logic [15:0] exp);
    check_bits({10'h0, p0_oe, p1_oe, p0_out, p1_out, ev0_core, ev1_core}, exp);
  endtask : status

  task automatic ir_load(input logic [3:0] v);
    u_tester.scan(5, 16'h001f, 16'hffff, tdo_v, oe_v, chg_v);
    u_tester.scan(11, 16'h0306, {7'h0, v, 5'h0}, tdo_v, oe_v, chg_v);
    check_bits(oe_v, 16'h01e0);
    check_bits(tdo_v & 16'h01e0, 16'h0020);
    check_bits(chg_v, 16'h0000);
  endtask : ir_load

  task automatic dr_scan(input int n, input logic [15:0] din, input logic [15:0] exp);
    logic [15:0] mask;
    mask = (16'h0001 << n) - 16'h0001;
    u_tester.scan(n + 5, 16'h0001 | (16'h0001 << (n + 2)) | (16'h0001 << (n + 3)),
                  din << 3, tdo_v, oe_v, chg_v);
    check_bits(oe_v, mask << 3);
    check_bits((tdo_v >> 3) & mask, exp);
    check_bits(chg_v, 16'h0000);
  endtask : dr_scan

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic test_float;
    check_bits({13'h0, tdo_oe, scan_on, flt}, 16'h0000);
    u_tester.set_pins(1'b0, 1'b1, 1'b0);
    settle();
    check_bits({15'h0, flt}, 16'h0001);
    u_tester.set_pins(1'b0, 1'b0, 1'b0);
    settle();
    check_bits({15'h0, flt}, 16'h0000);
    u_tester.set_pins(1'b1, 1'b1, 1'b0);
    settle();
    check_bits({14'h0, scan_on, flt}, 16'h0002);
    $display("test float done");
  endtask : test_float

  task automatic test_bypass;
    ir_load(stf_pkg::INSN_BYPASS);
    dr_scan(3, 16'h0005, 16'h0002);
    ir_load(4'h5);
    dr_scan(3, 16'h0003, 16'h0006);
    $display("test bypass done");
  endtask : test_bypass

  task automatic test_events;
    ev0 = 1'b1;
    ir_load(stf_pkg::INSN_EMU_CTRL);
    dr_scan(2, 16'h0001, 16'h0001);
    settle();
    status(16'h0028);
    ev0 = 1'b0;
    u_tester.set_pins(1'b1, 1'b1, 1'b1);
    settle();
    status(16'h0021);
    ev1 = 1'b1;
    dr_scan(2, 16'h0002, 16'h0002);
    settle();
    status(16'h0016);
    check_bits({15'h0, flt}, 16'h0000);
    $display("test events done");
  endtask : test_events

  task automatic test_trst_low;
    u_tester.set_pins(1'b0, 1'b0, 1'b1);
    settle();
    check_bits({13'h0, p0_oe, p1_oe, scan_on}, 16'h0000);
    u_tester.scan(11, 16'h0306, 16'h0000, tdo_v, oe_v, chg_v);
    check_bits(oe_v, 16'h0000);
    $display("test trst low done");
  endtask : test_trst_low

  // ---------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {rst, ev0, ev1} = 3'h4;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    settle();
    test_float();
    test_bypass();
    test_events();
    test_trst_low();
    test_done();
  end

  // The whole run needs about 8 us, so this only trips on a hang.
  initial begin
    #200us;
    mismatches++;
    test_done();
  end
endmodule : stf_top_test
